// ===== sef_pkg.sv
package sef_pkg;

    // ==========================================================
    // Group framing
    localparam logic [7:0]  LEN_MIN      = 8'h04;
    localparam logic [7:0]  LEN_MAX      = 8'h9b;
    localparam logic [7:0]  STATUS_LEN   = 8'h04;
    localparam logic [7:0]  CMD_HDR_LEN  = 8'h07;
    localparam logic [7:0]  CRC_TAIL_LEN = 8'h02;
    localparam logic [15:0] CRC_POLY     = 16'h8005;
    localparam logic [15:0] CRC_INIT     = 16'h0000;

    // ==========================================================
    // Status codes of four-byte groups
    localparam logic [7:0] ST_OK         = 8'h00;
    localparam logic [7:0] ST_MISCOMPARE = 8'h01;
    localparam logic [7:0] ST_PARSE      = 8'h03;
    localparam logic [7:0] ST_ECC_FAULT  = 8'h05;
    localparam logic [7:0] ST_SELF_TEST  = 8'h07;
    localparam logic [7:0] ST_HEALTH     = 8'h08;
    localparam logic [7:0] ST_EXEC       = 8'h0f;
    localparam logic [7:0] ST_WAKE       = 8'h11;
    localparam logic [7:0] ST_WATCHDOG   = 8'hee;
    localparam logic [7:0] ST_COMM       = 8'hff;

    // ==========================================================
    // States
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_RX   = 2'b01,
        S_BUSY = 2'b10
    } sef_dev_state_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SEND = 2'b01,
        H_RECV = 2'b10
    } sef_host_state_t;

    // ==========================================================
    // One byte into the checksum, low bit first
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        logic        fb;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            fb = b[i] ^ c[15];
            c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

endpackage

// ===== sef_link_if.sv
`timescale 1ns/1ps
interface sef_link_if;
    logic       h2d_valid;
    logic [7:0] h2d_data;
    logic       h2d_ready;
    logic       d2h_valid;
    logic [7:0] d2h_data;
    logic       d2h_ready;

    modport dev  (input h2d_valid, h2d_data, d2h_ready, output h2d_ready, d2h_valid, d2h_data);
    modport host (output h2d_valid, h2d_data, d2h_ready, input h2d_ready, d2h_valid, d2h_data);
endinterface

// ===== sef_fifo.sv
`timescale 1ns/1ps
module sef_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock, reset, enable
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic         en,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (en && push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (en) begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ===== sef_dev_end.sv
`timescale 1ns/1ps
module sef_dev_end #(
    parameter int FIFO_DEPTH = 4
) (
    // Clock, reset, enable
    input  wire logic  ref_clk,
    input  wire logic  rstn,
    input  wire logic  en,
    // Link
    sef_link_if.dev    lnk,
    // Packet bytes toward the executor
    output logic       cmd_valid,
    output logic [7:0] cmd_data,
    input  wire logic  cmd_ready,
    output logic       cmd_go,
    output logic       busy,
    // Execution result
    input  wire logic       exec_done,
    input  wire logic [7:0] exec_code,
    input  wire logic       exec_rng,
    // Device conditions
    input  wire logic  wake,
    input  wire logic  wdt_low,
    input  wire logic  st_fail,
    input  wire logic  rng_fail,
    input  wire logic  fail_clr
);
    // ==========================================================
    // State
    sef_pkg::sef_dev_state_t st_q;
    logic [7:0]  idx_q;
    logic [7:0]  cnt_q;
    logic [15:0] crc_q;
    logic [7:0]  crc_lo_q;
    logic [7:0]  byte_q;
    logic        pend_q;
    logic        h2d_ready_q;
    logic        go_q;
    logic        busy_q;
    logic        issued_q;
    logic [7:0]  rsp_code_q;
    logic        rsp_new_q;
    logic        st_fail_q;
    logic        rng_fail_q;
    logic [1:0]  tx_idx_q;
    logic        tx_pend_q;
    logic        d2h_valid_q;
    logic [7:0]  d2h_data_q;
    logic        fifo_in_ready;
    logic        h2d_take;
    logic [15:0] rsp_crc;
    logic [7:0]  tx_byte;

    assign lnk.h2d_ready = h2d_ready_q;
    assign lnk.d2h_valid = d2h_valid_q;
    assign lnk.d2h_data  = d2h_data_q;
    assign cmd_go        = go_q;
    assign busy          = busy_q;
    assign h2d_take      = lnk.h2d_valid && h2d_ready_q;

    // ==========================================================
    // Packet buffer
    sef_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .en        (en),
        .in_valid  (pend_q),
        .in_data   (byte_q),
        .in_ready  (fifo_in_ready),
        .out_valid (cmd_valid),
        .out_data  (cmd_data),
        .out_ready (cmd_ready)
    );

    // ==========================================================
    // Sticky failure conditions, set wins over clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_fail_q  <= 1'b0;
            rng_fail_q <= 1'b0;
        end else if (en) begin
            st_fail_q  <= st_fail || (st_fail_q && !fail_clr);
            rng_fail_q <= rng_fail || (rng_fail_q && !fail_clr);
        end
    end

    // ==========================================================
    // Receive and command control
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q        <= sef_pkg::S_IDLE;
            idx_q       <= 8'h00;
            cnt_q       <= 8'h00;
            crc_q       <= sef_pkg::CRC_INIT;
            crc_lo_q    <= 8'h00;
            byte_q      <= 8'h00;
            pend_q      <= 1'b0;
            h2d_ready_q <= 1'b0;
            go_q        <= 1'b0;
            busy_q      <= 1'b0;
            issued_q    <= 1'b0;
            rsp_code_q  <= 8'h00;
            rsp_new_q   <= 1'b0;
        end else if (en) begin
            rsp_new_q <= 1'b0;
            go_q      <= 1'b0;
            if (pend_q && fifo_in_ready) begin
                pend_q <= 1'b0;
            end
            case (st_q)
                sef_pkg::S_IDLE, sef_pkg::S_RX: begin
                    if (h2d_take) begin
                        h2d_ready_q <= 1'b0;
                        idx_q       <= idx_q + 8'h01;
                        if (st_q == sef_pkg::S_IDLE) begin
                            if (lnk.h2d_data < sef_pkg::LEN_MIN || lnk.h2d_data > sef_pkg::LEN_MAX) begin
                                rsp_code_q <= sef_pkg::ST_COMM;
                                rsp_new_q  <= 1'b1;
                                idx_q      <= 8'h00;
                            end else begin
                                cnt_q <= lnk.h2d_data;
                                crc_q <= sef_pkg::crc_byte(sef_pkg::CRC_INIT, lnk.h2d_data);
                                st_q  <= sef_pkg::S_RX;
                            end
                        end else if (idx_q < cnt_q - sef_pkg::CRC_TAIL_LEN) begin
                            crc_q  <= sef_pkg::crc_byte(crc_q, lnk.h2d_data);
                            byte_q <= lnk.h2d_data;
                            pend_q <= 1'b1;
                        end else if (idx_q == cnt_q - sef_pkg::CRC_TAIL_LEN) begin
                            crc_lo_q <= lnk.h2d_data;
                        end else begin
                            idx_q <= 8'h00;
                            if ({lnk.h2d_data, crc_lo_q} != crc_q) begin
                                // Comm fault outranks every other code
                                rsp_code_q <= sef_pkg::ST_COMM;
                                rsp_new_q  <= 1'b1;
                                st_q       <= sef_pkg::S_IDLE;
                            end else begin
                                st_q   <= sef_pkg::S_BUSY;
                                busy_q <= 1'b1;
                            end
                        end
                    end else begin
                        h2d_ready_q <= !pend_q || fifo_in_ready;
                        if (st_q == sef_pkg::S_IDLE && wake) begin
                            rsp_code_q <= sef_pkg::ST_WAKE;
                            rsp_new_q  <= 1'b1;
                        end
                    end
                end
                sef_pkg::S_BUSY: begin
                    h2d_ready_q <= 1'b0;
                    if (!issued_q) begin
                        if (st_fail_q) begin
                            rsp_code_q <= sef_pkg::ST_SELF_TEST;
                            rsp_new_q  <= 1'b1;
                            st_q       <= sef_pkg::S_IDLE;
                            busy_q     <= 1'b0;
                        end else if (wdt_low) begin
                            rsp_code_q <= sef_pkg::ST_WATCHDOG;
                            rsp_new_q  <= 1'b1;
                            st_q       <= sef_pkg::S_IDLE;
                            busy_q     <= 1'b0;
                        end else if (!cmd_valid && !pend_q) begin
                            go_q     <= 1'b1;
                            issued_q <= 1'b1;
                        end
                    end else if (exec_done) begin
                        // Executor decides surplus bytes versus parse error
                        rsp_code_q <= (exec_rng && rng_fail_q) ? sef_pkg::ST_HEALTH : exec_code;
                        rsp_new_q  <= 1'b1;
                        issued_q   <= 1'b0;
                        st_q       <= sef_pkg::S_IDLE;
                        busy_q     <= 1'b0;
                    end
                end
                default: begin
                    st_q <= sef_pkg::S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Answer group: length, code, CRC low, CRC high
    assign rsp_crc = sef_pkg::crc_byte(sef_pkg::crc_byte(sef_pkg::CRC_INIT, sef_pkg::STATUS_LEN), rsp_code_q);

    always_comb begin
        case (tx_idx_q)
            2'h0:    tx_byte = sef_pkg::STATUS_LEN;
            2'h1:    tx_byte = rsp_code_q;
            2'h2:    tx_byte = rsp_crc[7:0];
            default: tx_byte = rsp_crc[15:8];
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_idx_q    <= 2'h0;
            tx_pend_q   <= 1'b0;
            d2h_valid_q <= 1'b0;
            d2h_data_q  <= 8'h00;
        end else if (en) begin
            if (rsp_new_q) begin
                tx_idx_q    <= 2'h0;
                tx_pend_q   <= 1'b1;
                d2h_valid_q <= 1'b0;
            end else if (st_q != sef_pkg::S_IDLE || h2d_take) begin
                d2h_valid_q <= 1'b0;
            end else if (d2h_valid_q && lnk.d2h_ready) begin
                d2h_valid_q <= 1'b0;
                if (tx_idx_q == 2'h3) begin
                    tx_pend_q <= 1'b0;
                end else begin
                    tx_idx_q <= tx_idx_q + 2'h1;
                end
            end else if (!d2h_valid_q && tx_pend_q) begin
                d2h_valid_q <= 1'b1;
                d2h_data_q  <= tx_byte;
            end
        end
    end
endmodule

// ===== sef_host_end.sv
`timescale 1ns/1ps
module sef_host_end (
    // Clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        en,
    // Link
    sef_link_if.host         lnk,
    // Command request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  first_parameter,
    input  wire logic [15:0] second_parameter,
    input  wire logic [7:0]  dat_len,
    // Optional input data
    input  wire logic        dat_valid,
    input  wire logic [7:0]  dat_data,
    output logic             dat_ready,
    // Answer
    output logic             rsp_valid,
    output logic [7:0]       rsp_code,
    output logic [7:0]       rsp_len,
    output logic             rsp_ok
);
    // ==========================================================
    // State
    sef_pkg::sef_host_state_t st_q;
    logic [7:0]  idx_q;
    logic [7:0]  cnt_q;
    logic [15:0] crc_q;
    logic [7:0]  crc_lo_q;
    logic [7:0]  op_q;
    logic [7:0]  p1_q;
    logic [15:0] p2_q;
    logic        h2d_valid_q;
    logic [7:0]  h2d_data_q;
    logic        d2h_ready_q;
    logic        dat_ready_q;
    logic        req_ready_q;
    logic        rsp_valid_q;
    logic [7:0]  rsp_code_q;
    logic [7:0]  rsp_len_q;
    logic        rsp_ok_q;
    logic [7:0]  nxt_byte;
    logic        nxt_is_data;

    assign lnk.h2d_valid = h2d_valid_q;
    assign lnk.h2d_data  = h2d_data_q;
    assign lnk.d2h_ready = d2h_ready_q;
    assign req_ready     = req_ready_q;
    assign dat_ready     = dat_ready_q;
    assign rsp_valid     = rsp_valid_q;
    assign rsp_code      = rsp_code_q;
    assign rsp_len       = rsp_len_q;
    assign rsp_ok        = rsp_ok_q;

    // ==========================================================
    // Command byte at position idx_q
    always_comb begin
        nxt_is_data = 1'b0;
        case (idx_q)
            8'h00:   nxt_byte = cnt_q;
            8'h01:   nxt_byte = op_q;
            8'h02:   nxt_byte = p1_q;
            8'h03:   nxt_byte = p2_q[7:0];
            8'h04:   nxt_byte = p2_q[15:8];
            default: begin
                if (idx_q == cnt_q - sef_pkg::CRC_TAIL_LEN) begin
                    nxt_byte = crc_q[7:0];
                end else if (idx_q == cnt_q - 8'h01) begin
                    nxt_byte = crc_q[15:8];
                end else begin
                    nxt_byte    = dat_data;
                    nxt_is_data = 1'b1;
                end
            end
        endcase
    end

    // ==========================================================
    // Send command group, then collect answer group
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q        <= sef_pkg::H_IDLE;
            idx_q       <= 8'h00;
            cnt_q       <= 8'h00;
            crc_q       <= sef_pkg::CRC_INIT;
            crc_lo_q    <= 8'h00;
            op_q        <= 8'h00;
            p1_q        <= 8'h00;
            p2_q        <= 16'h0000;
            h2d_valid_q <= 1'b0;
            h2d_data_q  <= 8'h00;
            d2h_ready_q <= 1'b0;
            dat_ready_q <= 1'b0;
            req_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_code_q  <= 8'h00;
            rsp_len_q   <= 8'h00;
            rsp_ok_q    <= 1'b0;
        end else if (en) begin
            rsp_valid_q <= 1'b0;
            case (st_q)
                sef_pkg::H_IDLE: begin
                    req_ready_q <= 1'b1;
                    if (req_valid && req_ready_q) begin
                        req_ready_q <= 1'b0;
                        op_q        <= opcode;
                        p1_q        <= first_parameter;
                        p2_q        <= second_parameter;
                        cnt_q       <= sef_pkg::CMD_HDR_LEN + dat_len;
                        crc_q       <= sef_pkg::CRC_INIT;
                        idx_q       <= 8'h00;
                        st_q        <= sef_pkg::H_SEND;
                    end
                end
                sef_pkg::H_SEND: begin
                    if (h2d_valid_q && lnk.h2d_ready) begin
                        h2d_valid_q <= 1'b0;
                        idx_q       <= idx_q + 8'h01;
                        if (idx_q < cnt_q - sef_pkg::CRC_TAIL_LEN) begin
                            crc_q <= sef_pkg::crc_byte(crc_q, h2d_data_q);
                        end
                        if (idx_q == cnt_q - 8'h01) begin
                            // Whole group out before any read
                            idx_q       <= 8'h00;
                            d2h_ready_q <= 1'b1;
                            st_q        <= sef_pkg::H_RECV;
                        end
                    end else if (!h2d_valid_q && nxt_is_data) begin
                        dat_ready_q <= 1'b1;
                        if (dat_valid && dat_ready_q) begin
                            dat_ready_q <= 1'b0;
                            h2d_data_q  <= dat_data;
                            h2d_valid_q <= 1'b1;
                        end
                    end else if (!h2d_valid_q) begin
                        h2d_data_q  <= nxt_byte;
                        h2d_valid_q <= 1'b1;
                    end
                end
                sef_pkg::H_RECV: begin
                    if (lnk.d2h_valid && d2h_ready_q) begin
                        idx_q <= idx_q + 8'h01;
                        if (idx_q == 8'h00) begin
                            rsp_len_q <= lnk.d2h_data;
                            crc_q     <= sef_pkg::crc_byte(sef_pkg::CRC_INIT, lnk.d2h_data);
                            if (lnk.d2h_data < sef_pkg::LEN_MIN || lnk.d2h_data > sef_pkg::LEN_MAX) begin
                                rsp_ok_q    <= 1'b0;
                                rsp_valid_q <= 1'b1;
                                d2h_ready_q <= 1'b0;
                                st_q        <= sef_pkg::H_IDLE;
                            end
                        end else if (idx_q < rsp_len_q - sef_pkg::CRC_TAIL_LEN) begin
                            crc_q <= sef_pkg::crc_byte(crc_q, lnk.d2h_data);
                            if (idx_q == 8'h01) begin
                                rsp_code_q <= lnk.d2h_data;
                            end
                        end else if (idx_q == rsp_len_q - sef_pkg::CRC_TAIL_LEN) begin
                            crc_lo_q <= lnk.d2h_data;
                        end else begin
                            rsp_ok_q    <= ({lnk.d2h_data, crc_lo_q} == crc_q);
                            rsp_valid_q <= 1'b1;
                            d2h_ready_q <= 1'b0;
                            st_q        <= sef_pkg::H_IDLE;
                        end
                    end
                end
                default: begin
                    st_q <= sef_pkg::H_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== sef_chk_props.sv
`timescale 1ns/1ps
module sef_chk_props (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rstn,
    // Link
    input wire logic       h2d_valid,
    input wire logic [7:0] h2d_data,
    input wire logic       h2d_ready,
    input wire logic       d2h_valid,
    input wire logic [7:0] d2h_data,
    input wire logic       d2h_ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic       h_tk;
    logic       d_tk;
    logic [1:0] idx_q;
    assign h_tk = h2d_valid && h2d_ready;
    assign d_tk = d2h_valid && d2h_ready;
    // Byte position in answer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            idx_q <= 2'h0;
        end else if (d_tk) begin
            idx_q <= idx_q + 2'h1;
        end
    end
    chk_h2d_gap: assert property (h_tk |=> !h2d_ready)
        else $error("ready held after take");
    chk_host_gap: assert property (h_tk |=> !h2d_valid)
        else $error("host valid held after take");
    chk_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
        else $error("host byte changed");
    chk_d2h_hold: assert property (d2h_valid && !d2h_ready && !h_tk |=> !d2h_valid || $stable(d2h_data))
        else $error("answer byte changed");
    chk_count_byte: assert property (d2h_valid && idx_q == 2'h0 |-> d2h_data == sef_pkg::STATUS_LEN)
        else $error("answer count wrong");
    chk_no_read: assert property (h_tk |=> !d2h_valid)
        else $error("answer during receive");
    chk_d2h_gap: assert property (d_tk && idx_q != 2'h3 |=> !d2h_valid ##1 d2h_valid)
        else $error("answer byte spacing");
    chk_host_done: assert property (d_tk && idx_q == 2'h3 |-> ##[1:2] !d2h_ready)
        else $error("host still reading");
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        en = 1'b1;
    logic        req_valid = 1'b0;
    logic        dat_valid = 1'b1;
    logic        cmd_ready = 1'b0;
    logic        exec_done = 1'b0;
    logic        exec_rng = 1'b0;
    logic        wake = 1'b0;
    logic        wdt_low = 1'b0;
    logic        st_fail = 1'b0;
    logic        rng_fail = 1'b0;
    logic        fail_clr = 1'b0;
    logic [7:0]  opcode = 8'h00;
    logic [7:0]  first_parameter = 8'h00;
    logic [15:0] second_parameter = 16'h0000;
    logic [7:0]  dat_len = 8'h00;
    logic [7:0]  dat_data = 8'h00;
    logic [7:0]  exec_code = 8'h00;
    logic        req_ready, dat_ready, rsp_valid, rsp_ok, cmd_go, go2;
    logic [7:0]  rsp_code, rsp_len, hq[$], dq[$], dq2[$], gb[$];
    logic [15:0] c;
    logic [7:0]  cds[5] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h0f};
    logic [7:0]  lns[5] = '{8'h00, 8'h01, 8'h03, 8'h94, 8'h02};
    int          miscompares = 0;
    int          n_tests = 0;
    int          n_go2 = 0;
    int          n_bz = 0;
    int          n_bzr = 0;
    logic        cv, bz;
    logic [7:0]  cd, cq[$];
    always #12.5 ref_clk = ~ref_clk;
    sef_link_if lnk ();
    sef_link_if lnk2 ();
    sef_host_end i_sef_host_end (.ref_clk, .rstn, .en, .lnk(lnk.host), .req_valid, .req_ready, .opcode,
        .first_parameter, .second_parameter, .dat_len, .dat_valid, .dat_data, .dat_ready, .rsp_valid,
        .rsp_code, .rsp_len, .rsp_ok);
    sef_dev_end i_sef_dev_end (.ref_clk, .rstn, .en, .lnk(lnk.dev), .cmd_valid(cv), .cmd_data(cd), .cmd_ready,
        .cmd_go, .busy(bz), .exec_done, .exec_code, .exec_rng, .wake, .wdt_low, .st_fail, .rng_fail, .fail_clr);
    sef_dev_end i_sef_dev_end_b (.ref_clk, .rstn, .en, .lnk(lnk2.dev), .cmd_valid(), .cmd_data(),
        .cmd_ready, .cmd_go(go2), .busy(), .exec_done, .exec_code, .exec_rng, .wake, .wdt_low, .st_fail,
        .rng_fail, .fail_clr);
    sef_chk_props i_sef_chk_props (.ref_clk, .rstn, .h2d_valid(lnk.h2d_valid), .h2d_data(lnk.h2d_data),
        .h2d_ready(lnk.h2d_ready), .d2h_valid(lnk.d2h_valid), .d2h_data(lnk.d2h_data), .d2h_ready(lnk.d2h_ready));
    // Executor stand-in and wire monitors
    always @(posedge ref_clk) begin
        cmd_ready <= ~cmd_ready;
        exec_done <= cmd_go;
        if (dat_valid && dat_ready) dat_data <= dat_data + 8'h01;
        if (lnk.h2d_valid && lnk.h2d_ready) hq.push_back(lnk.h2d_data);
        if (lnk.d2h_valid && lnk.d2h_ready) dq.push_back(lnk.d2h_data);
        if (lnk2.d2h_valid && lnk2.d2h_ready) dq2.push_back(lnk2.d2h_data);
        if (go2) n_go2++;
        if (cv && cmd_ready) cq.push_back(cd);
        if (bz) n_bz++;
        if (bz && lnk.h2d_ready) n_bzr++;
    end
    function automatic logic [15:0] fcrc(input logic [7:0] q[$], input int n);
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < n * 8; k++) r = {r[14:0], 1'b0} ^ ((q[k/8][k%8] ^ r[15]) ? sef_pkg::CRC_POLY : 16'h0000);
        return r;
    endfunction
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task give_verdict();
        if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task run(input logic [7:0] len, input logic [7:0] code, input logic rng, input logic [7:0] exp);
        hq.delete();
        dq.delete();
        cq.delete();
        n_bz = 0;
        n_bzr = 0;
        exec_code <= code;
        exec_rng <= rng;
        dat_len <= len;
        opcode <= len ^ 8'h5a;
        first_parameter <= code;
        second_parameter <= {code, ~len};
        req_valid <= 1'b1;
        @(negedge ref_clk);
        for (int t = 0; t < 99 && !req_ready; t++) @(negedge ref_clk);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        for (int t = 0; t < 999 && !rsp_valid; t++) @(negedge ref_clk);
        cmp(rsp_valid, 32'h1);
        cmp(cq.size(), hq.size() - 3);
        cmp({cq[0], cq[cq.size()-1]}, {hq[1], hq[hq.size()-3]});
        cmp({n_bz != 0, n_bzr[7:0]}, 9'h100);
        cmp(rsp_code, exp);
        cmp({rsp_ok, rsp_len}, 9'h104);
        cmp(hq[0], len + 8'h07);
        cmp({hq[1], hq[2], hq[4], hq[3]}, {opcode, first_parameter, second_parameter});
        cmp(fcrc(hq, hq.size() - 2), {hq[hq.size()-1], hq[hq.size()-2]});
        cmp({dq[0], dq[1]}, {8'h04, exp});
        cmp(fcrc(dq, 2), {dq[3], dq[2]});
        @(posedge ref_clk);
    endtask
    // Raw group into the second device, answer must be a comm error
    task bad(input logic [7:0] b[$]);
        dq2.delete();
        n_go2 = 0;
        foreach (b[k]) begin
            lnk2.h2d_data <= b[k];
            lnk2.h2d_valid <= 1'b1;
            @(negedge ref_clk);
            for (int t = 0; t < 99 && !lnk2.h2d_ready; t++) @(negedge ref_clk);
            @(posedge ref_clk);
        end
        lnk2.h2d_valid <= 1'b0;
        lnk2.d2h_ready <= 1'b1;
        for (int t = 0; t < 99 && dq2.size() < 4; t++) @(negedge ref_clk);
        @(posedge ref_clk);
        lnk2.d2h_ready <= 1'b0;
        cmp({dq2[0], dq2[1], n_go2[7:0]}, 24'h04ff00);
    endtask
    initial begin
        lnk2.h2d_valid = 1'b0;
        lnk2.h2d_data = 8'h00;
        lnk2.d2h_ready = 1'b0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        foreach (cds[i]) run(lns[i], cds[i], 1'b0, cds[i]);
        wdt_low <= 1'b1;
        run(8'h00, 8'h00, 1'b0, 8'hee);
        wdt_low <= 1'b0;
        rng_fail <= 1'b1;
        @(posedge ref_clk);
        rng_fail <= 1'b0;
        run(8'h00, 8'h00, 1'b1, 8'h08);
        run(8'h01, 8'h00, 1'b0, 8'h00);
        st_fail <= 1'b1;
        @(posedge ref_clk);
        st_fail <= 1'b0;
        run(8'h00, 8'h00, 1'b0, 8'h07);
        gb = '{8'h07, 8'h01, 8'h00, 8'h00, 8'h00};
        c = fcrc(gb, 5) ^ 16'h0001;
        gb.push_back(c[7:0]);
        gb.push_back(c[15:8]);
        bad(gb);
        run(8'h00, 8'h00, 1'b1, 8'h07);
        fail_clr <= 1'b1;
        @(posedge ref_clk);
        fail_clr <= 1'b0;
        run(8'h00, 8'h00, 1'b1, 8'h00);
        bad('{8'h03});
        bad('{8'h9c});
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        repeat (4) @(negedge ref_clk);
        cmp({lnk.d2h_valid, lnk.d2h_data}, 9'h104);
        @(posedge ref_clk);
        dq2.delete();
        lnk2.d2h_ready <= 1'b1;
        for (int t = 0; t < 99 && dq2.size() < 4; t++) @(negedge ref_clk);
        cmp({dq2[0], dq2[1]}, 16'h0411);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        give_verdict();
    end
endmodule
